// [hw/wwd_cnt_if.sv]
`timescale 1ns/1ps
interface wwd_cnt_if;
   logic       en;
   logic       clear;
   logic       tick;
   logic [4:0] ps;
   logic       timeout;
   logic       in_window;

   modport ctl (output en, output clear, output tick, output ps,
                input timeout, input in_window);
   modport cnt (input en, input clear, input tick, input ps,
                output timeout, output in_window);
endinterface

// [hw/wwd_count.sv]
`timescale 1ns/1ps
`include "wwd_params.svh"
module wwd_count (
   input  wire logic core_clk,  // system clock
   input  wire logic rstn,      // sync reset, active low
   wwd_cnt_if.cnt    cif        // control from the register side
);
   localparam int unsigned CW = `WWD_CNT_W;

   // postscaler settings above the maximum saturate
   function automatic logic [CW-1:0] wwd_period(input logic [4:0] ps);
      logic [4:0] p;
      p = (ps > 5'(`WWD_PS_MAX)) ? 5'(`WWD_PS_MAX) : ps;
      return CW'(1) << p;
   endfunction

   logic [CW-1:0] cnt_r;
   wire  [CW-1:0] period = wwd_period(cif.ps);
   wire  [CW-1:0] last   = period - CW'(1);
   wire  [CW-1:0] open_at = period - (period >> 2);

   assign cif.timeout   = cif.en & cif.tick & ~cif.clear & (cnt_r == last);
   // windows shorter than four ticks are always open
   assign cif.in_window = (cif.ps < 5'h02) | (cnt_r >= open_at);

   always_ff @(posedge core_clk) begin
      if (!rstn || !cif.en || cif.clear || cif.timeout)
         cnt_r <= '0;
      else if (cif.tick)
         cnt_r <= cnt_r + CW'(1);
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);

   a_clear_zeroes_cnt: assert property (cif.clear |=> cnt_r == '0)
      else $error("counter not zero after clear");
   a_disable_zeroes: assert property (!cif.en |=> cnt_r == '0)
      else $error("counter not zero while disabled");
   a_count_on_tick: assert property (!cif.tick && !cif.clear && cif.en |=> $stable(cnt_r))
      else $error("counter moved without a tick");
endmodule

// [hw/wwd_params.svh]
`ifndef WWD_PARAMS_SVH
`define WWD_PARAMS_SVH

// -----------------------------------------------------------------
// register map, byte addresses
// -----------------------------------------------------------------
`define WWD_ADDR_W       8
`define WWD_CTRL_OFS     8'h00
`define WWD_CTRL_CLR_OFS 8'h04
`define WWD_CTRL_SET_OFS 8'h08
`define WWD_CTRL_INV_OFS 8'h0c
`define WWD_STAT_OFS     8'h10
`define WWD_MASK_OFS     8'h14

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define WWD_ON_BIT       15
`define WWD_PS_MSB       6
`define WWD_PS_LSB       2
`define WWD_WIN_BIT      1
`define WWD_CLR_BIT      0
`define WWD_EV_TIMEOUT   0
`define WWD_EV_VIOL      1
`define WWD_EV_W         2

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define WWD_CTRL_RST     32'h0000_0000
`define WWD_EV_RST       2'h0

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define WWD_CLK_HZ       40000000
`define WWD_LOW_POWER_RC_CLOCK_HZ      32000
`define WWD_TICK_DIV     (`WWD_CLK_HZ / `WWD_LOW_POWER_RC_CLOCK_HZ)
`define WWD_PS_MAX       20
`define WWD_CNT_W        21

`endif

// [hw/wwd_pkg.sv]
package wwd_pkg;
   typedef enum logic [1:0] {
      OP_WR  = 2'b00,
      OP_CLR = 2'b01,
      OP_SET = 2'b10,
      OP_INV = 2'b11
   } wwd_op_e;

   typedef enum logic {
      ST_INIT = 1'b0,
      ST_RUN  = 1'b1
   } wwd_state_e;
endpackage

// [hw/wwd_tick.sv]
`timescale 1ns/1ps
`include "wwd_params.svh"
module wwd_tick #(
   parameter int unsigned DIV = `WWD_TICK_DIV
) (
   input  wire logic core_clk,  // system clock
   input  wire logic rstn,      // sync reset, active low
   output logic      tick       // one-cycle low-power rc clock enable
);
   localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;

   if (DIV < 1) begin : g_chk
      $error("wwd_tick: DIV must be at least 1");
   end

   logic [W-1:0] div_r;
   logic         tick_r;
   wire          wrap = (div_r == W'(DIV - 1));

   // free-running: the oscillator stands for a clock that never stops
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         div_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         div_r  <= wrap ? '0 : div_r + W'(1);
         tick_r <= wrap;
      end
   end

   assign tick = tick_r;
endmodule

// [hw/wwd_top.sv]
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "wwd_params.svh"
module wwd_top #(
   parameter int unsigned TICK_DIV = `WWD_TICK_DIV
) (
   input  wire logic                   core_clk,          // 40 mhz system clock
   input  wire logic                   rstn,              // sync reset, active low
   input  wire logic [`WWD_ADDR_W-1:0] addr,              // register byte address
   input  wire logic [31:0]            wr_data,           // write data
   input  wire logic                   wr_en,             // write strobe
   input  wire logic                   rd_en,             // read strobe
   output logic      [31:0]            rd_data,           // read data, cycle after rd_en
   input  wire logic                   config_enable,     // configuration enable strap
   input  wire logic [4:0]             config_postscaler, // configuration postscaler strap
   input  wire logic                   sleep_mode,        // device in sleep or idle
   output logic                        device_reset,      // one-cycle reset request
   output logic                        wake,              // one-cycle wake request
   output logic                        irq                // level interrupt
);
   localparam int unsigned EW = `WWD_EV_W;

   if (TICK_DIV < 1) begin : g_chk
      $error("wwd_top: TICK_DIV must be at least 1");
   end

   // -----------------------------------------------------------------
   // alias write arithmetic
   // -----------------------------------------------------------------
   function automatic logic [31:0] wwd_apply(input logic [31:0]      old,
                                             input logic [31:0]      wd,
                                             input wwd_pkg::wwd_op_e op);
      case (op)
         wwd_pkg::OP_WR:  return wd;
         wwd_pkg::OP_CLR: return old & ~wd;
         wwd_pkg::OP_SET: return old | wd;
         wwd_pkg::OP_INV: return old ^ wd;
         default:         return old;
      endcase
   endfunction

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   wwd_pkg::wwd_state_e state_r;
   logic                cfg_on_r;
   logic [4:0]          ps_r;
   logic                sw_on_r;
   logic                win_r;
   logic [EW-1:0]       stat_r;
   logic [EW-1:0]       mask_r;
   logic [31:0]         rd_data_r;
   logic                dev_rst_r;
   logic                wake_r;
   logic                irq_r;

   wwd_cnt_if cif ();

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   wire running  = cfg_on_r | sw_on_r;
   wire ctrl_sel = (addr[`WWD_ADDR_W-1:4] == '0) && (addr[1:0] == 2'b00);
   wire ctrl_wr  = wr_en & ctrl_sel;
   wire stat_wr  = wr_en & (addr == `WWD_STAT_OFS);
   wire mask_wr  = wr_en & (addr == `WWD_MASK_OFS);
   wire wwd_pkg::wwd_op_e op = wwd_pkg::wwd_op_e'(addr[3:2]);

   // reserved bits are hard zero in the view
   wire [31:0] ctrl_view;
   assign ctrl_view = {16'h0000, running, 8'h00, ps_r, win_r, 1'b0};
   wire [31:0] ctrl_new = wwd_apply(ctrl_view, wr_data, op);
   // the clear bit always reads zero, so set and invert of one also clear
   wire clr_req = ctrl_wr & ctrl_new[`WWD_CLR_BIT];

   wire viol = clr_req & running & win_r & ~cif.in_window;
   wire to   = cif.timeout;

   wire [EW-1:0] ev = {viol, to};
   // set wins over the write-one clear
   wire [EW-1:0] stat_nxt = (stat_r & ~(stat_wr ? wr_data[EW-1:0] : '0)) | ev;

   wire [31:0] rd_mux =
      (addr == `WWD_CTRL_OFS) ? ctrl_view :
      (addr == `WWD_STAT_OFS) ? {{(32-EW){1'b0}}, stat_r} :
      (addr == `WWD_MASK_OFS) ? {{(32-EW){1'b0}}, mask_r} : 32'h0000_0000;

   assign cif.en    = running;
   assign cif.clear = clr_req;
   assign cif.ps    = ps_r;

   // -----------------------------------------------------------------
   // straps, caught one cycle after reset release
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_r  <= wwd_pkg::ST_INIT;
         cfg_on_r <= 1'b0;
         ps_r     <= 5'h00;
      end else begin
         case (state_r)
            wwd_pkg::ST_INIT: begin
               cfg_on_r <= config_enable;
               ps_r     <= config_postscaler;
               state_r  <= wwd_pkg::ST_RUN;
            end
            wwd_pkg::ST_RUN: state_r <= wwd_pkg::ST_RUN;
            default:         state_r <= wwd_pkg::ST_INIT;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // software registers
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         sw_on_r <= 1'b0;
         win_r   <= 1'b0;
         stat_r  <= `WWD_EV_RST;
         mask_r  <= `WWD_EV_RST;
      end else begin
         if (ctrl_wr) begin
            sw_on_r <= ctrl_new[`WWD_ON_BIT];
            win_r   <= ctrl_new[`WWD_WIN_BIT];
         end
         stat_r <= stat_nxt;
         if (mask_wr)
            mask_r <= wr_data[EW-1:0];
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rd_data_r <= 32'h0000_0000;
         dev_rst_r <= 1'b0;
         wake_r    <= 1'b0;
         irq_r     <= 1'b0;
      end else begin
         rd_data_r <= rd_en ? rd_mux : 32'h0000_0000;
         dev_rst_r <= (to & ~sleep_mode) | viol;
         wake_r    <= to & sleep_mode;
         irq_r     <= |(stat_r & mask_r);
      end
   end

   assign rd_data      = rd_data_r;
   assign device_reset = dev_rst_r;
   assign wake         = wake_r;
   assign irq          = irq_r;

   wwd_tick #(
      .DIV (TICK_DIV)
   ) u_tick (
      .core_clk (core_clk),
      .rstn     (rstn),
      .tick     (cif.tick)
   );

   wwd_count u_count (
      .core_clk (core_clk),
      .rstn     (rstn),
      .cif      (cif)
   );

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);

   a_timeout_resets: assert property (to && !sleep_mode |=> device_reset && !wake)
      else $error("time-out did not reset the device");
   a_timeout_wakes: assert property (to && sleep_mode |=> wake && !device_reset)
      else $error("time-out in sleep did not wake");
   a_timeout_on_tick: assert property (to |-> cif.tick && running)
      else $error("time-out without an rc tick");
   a_cfg_stays_on: assert property (cfg_on_r && ctrl_wr |=> running)
      else $error("configuration enable lost by a write");
   a_on_readback: assert property (rd_en && addr == `WWD_CTRL_OFS && running
                                   |=> rd_data[`WWD_ON_BIT])
      else $error("on bit read zero while running");
   a_shadow_fixed: assert property (state_r == wwd_pkg::ST_RUN |=> $stable(ps_r))
      else $error("postscaler shadow changed after load");
   a_win_rst_zero: assert property ($rose(rstn) |-> !win_r)
      else $error("window enable not zero after reset");
   a_reserved_zero: assert property (rd_en |=> rd_data[31:16] == 16'h0000
                                     && rd_data[14:7] == 8'h00)
      else $error("reserved control bits read nonzero");
   a_alias_set: assert property (ctrl_wr && op == wwd_pkg::OP_SET && wr_data[`WWD_WIN_BIT]
                                 |=> win_r)
      else $error("set alias did not set window enable");
   a_alias_inv: assert property (ctrl_wr && op == wwd_pkg::OP_INV && wr_data[`WWD_WIN_BIT]
                                 |=> win_r != $past(win_r))
      else $error("invert alias did not toggle window enable");
   a_early_clear: assert property (viol |=> device_reset ##1 !device_reset)
      else $error("early windowed clear did not reset");
   // a one-tick period may legally expire on the very next tick
   a_clear_restart: assert property (clr_req && running && ps_r != 5'h00 |=> !to)
      else $error("time-out right after a clear");

   // -----------------------------------------------------------------
   // status and interrupt checks
   // -----------------------------------------------------------------
   a_stat_to_set: assert property (to |=> stat_r[`WWD_EV_TIMEOUT])
      else $error("time-out did not set status");
   a_stat_viol_set: assert property (viol |=> stat_r[`WWD_EV_VIOL])
      else $error("violation did not set status");
   a_stat_sticky: assert property (stat_r[0] && !(stat_wr && wr_data[0]) |=> stat_r[0])
      else $error("time-out status dropped without a clear");
   a_stat_w1c: assert property (stat_wr && wr_data[0] && !to |=> !stat_r[0])
      else $error("time-out status not cleared by writing one");
   a_irq_follows: assert property (|(stat_r & mask_r) |=> irq)
      else $error("interrupt low with an unmasked status bit");
   a_irq_quiet: assert property (!(|(stat_r & mask_r)) |=> !irq)
      else $error("interrupt high with no unmasked status bit");
   a_mask_write: assert property (mask_wr |=> mask_r == $past(wr_data[EW-1:0]))
      else $error("mask write lost");

   // -----------------------------------------------------------------
   // register view checks
   // -----------------------------------------------------------------
   a_rd_idle_zero: assert property (!rd_en |=> rd_data == 32'h0000_0000)
      else $error("read data not zero outside a read");
   a_rd_ctrl_view: assert property (rd_en && addr == `WWD_CTRL_OFS |=> rd_data == $past(ctrl_view))
      else $error("control read does not match its view");
   a_ps_readback: assert property (rd_en && addr == `WWD_CTRL_OFS && state_r == wwd_pkg::ST_RUN
                                   |=> rd_data[`WWD_PS_MSB:`WWD_PS_LSB] == ps_r)
      else $error("postscaler shadow read wrong");
   a_alias_read_zero: assert property (rd_en && ctrl_sel && addr[3:2] != 2'b00 |=> rd_data == '0)
      else $error("alias read not zero");
   a_alias_clr: assert property (ctrl_wr && op == wwd_pkg::OP_CLR && wr_data[`WWD_WIN_BIT]
                                 |=> !win_r)
      else $error("clear alias did not clear window enable");
   a_clr_alias_noclr: assert property (ctrl_wr && op == wwd_pkg::OP_CLR |-> !clr_req)
      else $error("clear alias raised a counter clear");

   // -----------------------------------------------------------------
   // control checks
   // -----------------------------------------------------------------
   a_sw_start: assert property (ctrl_wr && ctrl_new[`WWD_ON_BIT] |=> running)
      else $error("software enable did not start the timer");
   a_sw_stop: assert property (state_r == wwd_pkg::ST_RUN && !cfg_on_r && ctrl_wr
                               && !ctrl_new[`WWD_ON_BIT] |=> !running)
      else $error("software disable did not stop the timer");
   a_strap_load: assert property (state_r == wwd_pkg::ST_INIT
                                  |=> ps_r == $past(config_postscaler)
                                      && cfg_on_r == $past(config_enable))
      else $error("straps not captured after reset");
   a_win_write: assert property (ctrl_wr |=> win_r == $past(ctrl_new[`WWD_WIN_BIT]))
      else $error("window enable write lost");
   a_no_win_no_viol: assert property (!win_r |-> !viol)
      else $error("violation outside windowed mode");
   a_viol_needs_window: assert property (viol |-> running && !cif.in_window)
      else $error("violation inside the open window");
   a_clear_open_ok: assert property (clr_req && cif.in_window |=> !device_reset)
      else $error("clear in the open window reset the device");
   a_stopped_quiet: assert property (!running |-> !to)
      else $error("time-out while stopped");
   a_wake_in_sleep: assert property (wake |-> $past(sleep_mode))
      else $error("wake outside sleep");
   a_rst_has_cause: assert property (device_reset |-> $past(to) || $past(viol))
      else $error("device reset without a cause");

   c_timeout_run:   cover property (to && !sleep_mode);
   c_timeout_sleep: cover property (to && sleep_mode);
   c_violation:     cover property (viol);
   c_irq:           cover property (irq);
endmodule

// [testbench/wwd_top_tb.sv]
`timescale 1ns/1ps
`include "wwd_params.svh"
module wwd_top_tb;
   // ---------------------------------------------------------------
   // stimulus and observation
   // ---------------------------------------------------------------
   logic        core_clk          = 1'b0;
   logic        rstn              = 1'b0;
   logic [7:0]  addr              = 8'h00;
   logic [31:0] wr_data           = 32'h0000_0000;
   logic        wr_en             = 1'b0;
   logic        rd_en             = 1'b0;
   logic        config_enable     = 1'b0;
   logic [4:0]  config_postscaler = 5'h03;
   logic        sleep_mode        = 1'b0;
   logic [31:0] rd_data;
   logic        device_reset;
   logic        wake;
   logic        irq;
   int          mismatches        = 0;
   int          n_tests           = 0;
   int          n_rst             = 0;
   int          n_wake            = 0;

   always #12.5 core_clk = ~core_clk;

   // pulses counted so long waits never miss a one-cycle output
   always @(posedge core_clk) begin
      if (device_reset === 1'b1) n_rst++;
      if (wake === 1'b1) n_wake++;
   end

   // short divider keeps every time-out within a few hundred cycles
   wwd_top #(.TICK_DIV(4)) uut (
      .core_clk(core_clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .config_enable(config_enable), .config_postscaler(config_postscaler),
      .sleep_mode(sleep_mode), .device_reset(device_reset), .wake(wake), .irq(irq)
   );

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge core_clk);
      wr_en   <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1;
      chk(rd_data, e);
   endtask

   task automatic do_reset(input logic ce, input logic [4:0] ps);
      @(posedge core_clk);
      rstn              <= 1'b0;
      config_enable     <= ce;
      config_postscaler <= ps;
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      cyc(3);
   endtask

   // cycles until the next reset or wake pulse, bounded
   task automatic wait_ev(output int c);
      int r0;
      int w0;
      r0 = n_rst;
      w0 = n_wake;
      c  = 0;
      while (n_rst == r0 && n_wake == w0 && c < 400) begin
         @(posedge core_clk);
         #1;
         c++;
      end
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      do_reset(1'b0, 5'h03);
      rchk(`WWD_CTRL_OFS, 32'h0000_000c);
      wr(`WWD_CTRL_OFS, 32'hffff_7ffe);
      rchk(`WWD_CTRL_OFS, 32'h0000_000e);
      cyc(1);
      chk(rd_data, 32'h0000_0000);
      rchk(`WWD_STAT_OFS, 32'h0000_0000);
      rchk(`WWD_MASK_OFS, 32'h0000_0000);
      wr(8'h40, 32'hffff_ffff);
      rchk(8'h40, 32'h0000_0000);
      rchk(`WWD_CTRL_CLR_OFS, 32'h0000_0000);
      wr(`WWD_CTRL_SET_OFS, 32'h0000_8000);
      rchk(`WWD_CTRL_OFS, 32'h0000_800e);
      wr(`WWD_CTRL_CLR_OFS, 32'h0000_0002);
      rchk(`WWD_CTRL_OFS, 32'h0000_800c);
      wr(`WWD_CTRL_INV_OFS, 32'h0000_8002);
      cyc(1);
      rchk(`WWD_CTRL_OFS, 32'h0000_000e);
   endtask

   task automatic t_period;
      int c;
      int p;
      for (int ps = 1; ps <= 4; ps++) begin
         do_reset(1'b0, ps[4:0]);
         p = 4 * (1 << ps);
         wr(`WWD_CTRL_SET_OFS, 32'h0000_8000);
         wait_ev(c);
         chk({31'h0, (c >= p - 5 && c <= p + 4)}, 32'h1);
         chk(n_wake, 0);
         wr(`WWD_CTRL_OFS, 32'h0000_0000);
         rchk(`WWD_STAT_OFS, 32'h0000_0001);
         chk({31'h0, irq}, 32'h0);
         wr(`WWD_MASK_OFS, 32'h0000_0001);
         cyc(2);
         chk({31'h0, irq}, 32'h1);
         wr(`WWD_STAT_OFS, 32'h0000_0001);
         cyc(2);
         chk({31'h0, irq}, 32'h0);
      end
   endtask

   task automatic t_sleep;
      int c;
      int r0;
      int w0;
      r0 = n_rst;
      w0 = n_wake;
      @(posedge core_clk);
      sleep_mode <= 1'b1;
      wr(`WWD_CTRL_SET_OFS, 32'h0000_8000);
      wait_ev(c);
      cyc(1);
      chk(n_wake, w0 + 1);
      chk(n_rst, r0);
      wr(`WWD_CTRL_OFS, 32'h0000_0000);
      sleep_mode <= 1'b0;
      wr(`WWD_STAT_OFS, 32'h0000_0003);
   endtask

   // period 16 ticks, late quarter opens at count 12
   task automatic t_window;
      int r0;
      r0 = n_rst;
      wr(`WWD_CTRL_OFS, 32'h0000_8002);
      wr(`WWD_CTRL_SET_OFS, 32'h0000_0001);
      cyc(2);
      chk(n_rst, r0 + 1);
      rchk(`WWD_STAT_OFS, 32'h0000_0002);
      wr(`WWD_STAT_OFS, 32'h0000_0002);
      cyc(44);
      wr(`WWD_CTRL_SET_OFS, 32'h0000_0001);
      cyc(40);
      chk(n_rst, r0 + 1);
      wr(`WWD_CTRL_CLR_OFS, 32'h0000_8000);
      cyc(80);
      chk(n_rst, r0 + 1);
   endtask

   task automatic t_cfg;
      int c;
      int r0;
      do_reset(1'b1, 5'h02);
      rchk(`WWD_CTRL_OFS, 32'h0000_8008);
      wr(`WWD_CTRL_OFS, 32'h0000_0000);
      rchk(`WWD_CTRL_OFS, 32'h0000_8008);
      r0 = n_rst;
      wait_ev(c);
      chk(n_rst, r0 + 1);
   endtask

   // ---------------------------------------------------------------
   // sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      t_regs();
      t_period();
      t_sleep();
      t_window();
      t_cfg();
      give_verdict();
   end

   // whole run needs well under 2000 cycles
   initial begin
      cyc(6000);
      mismatches++;
      $display("MISMATCH at %0t: run did not finish", $time);
      give_verdict();
   end
endmodule
